/* wdrc_defines.vh */
// Constants for the watchdog and reset control block
`ifndef WDRC_DEFINES_VH
`define WDRC_DEFINES_VH
// Register byte addresses
`define WDRC_ADDR_TSEL      4'h0
`define WDRC_ADDR_CTRL      4'h4
`define WDRC_ADDR_STATUS    4'h8
`define WDRC_ADDR_CAUSE     4'hc
// Field positions and reset values
`define WDRC_TSEL_RST       3'h7
`define WDRC_KEY_OFF        4'ha
`define WDRC_KEY_RST        4'ha
`define WDRC_PORT_RST       8'hff
`define WDRC_ST_EXPIRED     0
`define WDRC_ST_PDOWN       1
`define WDRC_ST_INRESET     2
`define WDRC_ST_SLEEP       3
// Watchdog counter and timing
`define WDRC_CNT_W          15
`define WDRC_TSEL_BASE      8
`define WDRC_CLK_MHZ        40
`define WDRC_RSTD_US        50000
`define WDRC_RSTD_CYC       (`WDRC_RSTD_US * `WDRC_CLK_MHZ)
`define WDRC_SST_LONG       8'h80
`define WDRC_SST_SHORT      8'h02
`define WDRC_BOD_NS         250
`define WDRC_BOD_CYC        ((`WDRC_BOD_NS * `WDRC_CLK_MHZ + 999) / 1000)
// Watchdog clock source select codes
`define WDRC_SRC_LXT        2'h0
`define WDRC_SRC_SYSDIV4    2'h1
`define WDRC_SRC_LOW_INTERNAL_RC_OSC       2'h2
// Oscillator type codes
`define WDRC_OSC_ERC        2'h0
`define WDRC_OSC_HIGH_INTERNAL_RC_OSC       2'h1
`define WDRC_OSC_XTAL       2'h2
`endif

/* wdrc_sync.v */
// Two-flop synchroniser bank for asynchronous inputs
`timescale 1ns/1ps
module wdrc_sync #(
  parameter W = 4
) (
  input  wire         sys_clk,
  input  wire         arst_n,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] meta;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= {W{1'b1}};
      dout <= {W{1'b1}};
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // wdrc_sync

/* wdrc_top.v */
// Watchdog timer and reset control with Avalon-MM register slave
// Notes on behaviour
// - Expiry while running resets the device and sets the expired flag.
// - Expiry while sleeping wakes, sets expired flag, clears only PC and stack.
// - Counter clears on clear pin low, software clear, or sleep.
// - Configuration picks single clear or paired clear instructions.
// - Single mode: one clear instruction clears the counter at once.
// - Paired mode: only alternation clears; repeating one instruction does nothing. Here the first paired clear after power-on also clears.
// - Period is 2 to the (8 plus select) watchdog clock periods.
// - Upper five select bits read zero; select powers up as 111.
// - Power-on sets program counter to zero.
// - Power-on loads all ones into port data and direction registers.
// - After clear pin release wait reset delay before running.
// - Clear pin low while running restarts from program counter zero.
// - Enabled low-voltage reset fires only after dips longer than filter time.
// - Running watchdog reset acts like pin reset plus expired flag.
// - Start-up delay 128 or 2 cycles for RC types, 128 for crystal.
// - Flags: power-on clears both; pin or brownout keep; watchdog sets per mode.
// - Power-on disables interrupts, clears watchdog, stops timers, stack at top.
// - Watchdog off only when option disabled and key equals 1010.
// - Sleep sets powerdown flag and clears expired flag.
// - Watchdog clock from low crystal, system clock over four, or low RC.
//
// Design decisions made here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "wdrc_defines.vh"
module wdrc_top #(
  parameter RSTD_CYC = `WDRC_RSTD_CYC
) (
  input  wire        sys_clk,
  input  wire        arst_n,
  // Configuration options
  input  wire        cfg_dog_enable,
  input  wire        cfg_paired_clear,
  input  wire [1:0]  cfg_dog_source,
  input  wire [1:0]  cfg_osc_type,
  input  wire        cfg_short_startup,
  input  wire        cfg_lvr_enable,
  // Pins and analog comparators
  input  wire        external_clear_pin_n,
  input  wire        brownout_low,
  input  wire        low_crystal_osc,
  input  wire        low_internal_rc_osc,
  // Core instruction strobes
  input  wire        clear_watchdog_single,
  input  wire        clear_watchdog_first,
  input  wire        clear_watchdog_second,
  input  wire        sleep_instruction,
  // Avalon-MM slave
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // Reset outputs to the core
  output reg         core_reset,
  output reg         pc_sp_clear,
  output reg         core_hold,
  output reg         sleeping,
  output reg         dog_expired_flag,
  output reg         powerdown_flag,
  output reg  [7:0]  port_init_value
);
  localparam ST_RUN   = 4'b0001;
  localparam ST_RESET = 4'b0010;
  localparam ST_DELAY = 4'b0100;
  localparam ST_SST   = 4'b1000;

  // Expiry tap for a select code
  function [`WDRC_CNT_W-1:0] tap_mask;
    input [2:0] sel;
    begin
      tap_mask = {`WDRC_CNT_W{1'b0}};
      tap_mask[sel] = 1'b1;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  // Supply-low enters inverted so the synchroniser's reset value reads as supply good
  wire [3:0] raw_in = {external_clear_pin_n, ~brownout_low, low_crystal_osc,
                       low_internal_rc_osc};
  wire [3:0] syn;
  wdrc_sync #(.W(4)) u_sync (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .din     (raw_in),
    .dout    (syn)
  );
  wire pin_low = ~syn[3];
  wire bod_low = ~syn[2];

  reg  [2:0]  timeout_select;
  reg  [3:0]  dog_enable_key;
  reg  [3:0]  state;
  reg  [31:0] delay_cnt;
  reg  [7:0]  bod_cnt;
  reg         bod_fire;
  reg  [1:0]  src_d;
  reg  [1:0]  div4;
  reg  [`WDRC_CNT_W+7:0] dog_cnt;
  reg         last_pair;
  reg         pair_valid;
  reg  [1:0]  last_cause;

  wire dog_on = cfg_dog_enable || (dog_enable_key != `WDRC_KEY_OFF);

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog clock tick
  reg src_tick;
  always @* begin
    case (cfg_dog_source)
      `WDRC_SRC_LXT:     src_tick = syn[1] & ~src_d[1];
      `WDRC_SRC_SYSDIV4: src_tick = (div4 == 2'h3) & ~sleeping;
      default:           src_tick = syn[0] & ~src_d[0];
    endcase
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      // Matches the synchroniser reset, so no false tick follows reset
      src_d <= 2'h3;
      div4  <= 2'h0;
    end else begin
      src_d <= syn[1:0];
      div4  <= div4 + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software clear decode
  wire pair_hit = (clear_watchdog_first &&
                   (!pair_valid || last_pair != 1'b0)) ||
                  (clear_watchdog_second &&
                   (!pair_valid || last_pair != 1'b1));
  wire sw_clear = cfg_paired_clear ? pair_hit : clear_watchdog_single;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      last_pair  <= 1'b0;
      pair_valid <= 1'b0;
    end else if (clear_watchdog_first || clear_watchdog_second) begin
      if (pair_hit || !pair_valid) begin
        pair_valid <= 1'b1;
        last_pair  <= clear_watchdog_second;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog counter
  wire [`WDRC_CNT_W-1:0] cnt_hi = dog_cnt[`WDRC_CNT_W+7:8];
  wire [`WDRC_CNT_W-1:0] tap = tap_mask(timeout_select);
  wire dog_expire = dog_on && (state == ST_RUN) && |(cnt_hi & tap);

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dog_cnt <= {(`WDRC_CNT_W+8){1'b0}};
    end else if (state != ST_RUN || sw_clear || sleep_instruction ||
                 dog_expire || !dog_on) begin
      dog_cnt <= {(`WDRC_CNT_W+8){1'b0}};
    end else if (src_tick) begin
      dog_cnt <= dog_cnt + {{(`WDRC_CNT_W+7){1'b0}}, 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Brownout filter
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bod_cnt  <= 8'h00;
      bod_fire <= 1'b0;
    end else if (cfg_lvr_enable && bod_low) begin
      if (bod_cnt == `WDRC_BOD_CYC) begin
        bod_fire <= 1'b1;
      end else begin
        bod_cnt <= bod_cnt + 8'h01;
      end
    end else begin
      bod_cnt  <= 8'h00;
      bod_fire <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset sequencer
  wire [7:0] sst_len = (cfg_osc_type != `WDRC_OSC_XTAL && cfg_short_startup) ?
                       `WDRC_SST_SHORT : `WDRC_SST_LONG;
  wire hard_req = pin_low || bod_fire;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state            <= ST_RESET;
      delay_cnt        <= 32'h0;
      core_reset       <= 1'b1;
      pc_sp_clear      <= 1'b0;
      core_hold        <= 1'b1;
      sleeping         <= 1'b0;
      dog_expired_flag <= 1'b0;
      powerdown_flag   <= 1'b0;
      port_init_value  <= `WDRC_PORT_RST;
      last_cause       <= 2'h0;
    end else begin
      pc_sp_clear <= 1'b0;
      case (state)
        ST_RUN: begin
          core_hold <= 1'b0;
          if (hard_req) begin
            state      <= ST_RESET;
            core_reset <= 1'b1;
            core_hold  <= 1'b1;
            sleeping   <= 1'b0;
            last_cause <= bod_fire ? 2'h2 : 2'h1;
          end else if (dog_expire && sleeping) begin
            sleeping         <= 1'b0;
            pc_sp_clear      <= 1'b1;
            core_hold        <= 1'b1;
            dog_expired_flag <= 1'b1;
            powerdown_flag   <= 1'b1;
            delay_cnt        <= 32'h0;
            state            <= ST_SST;
            last_cause       <= 2'h3;
          end else if (dog_expire) begin
            dog_expired_flag <= 1'b1;
            core_reset       <= 1'b1;
            core_hold        <= 1'b1;
            delay_cnt        <= 32'h0;
            state            <= ST_DELAY;
            last_cause       <= 2'h3;
          end else if (sleep_instruction) begin
            sleeping         <= 1'b1;
            powerdown_flag   <= 1'b1;
            dog_expired_flag <= 1'b0;
          end else if (sw_clear) begin
            powerdown_flag   <= 1'b0;
            dog_expired_flag <= 1'b0;
          end
        end
        ST_RESET: begin
          delay_cnt <= 32'h0;
          if (!hard_req) begin
            state <= ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (hard_req) begin
            state <= ST_RESET;
          end else if (delay_cnt >= RSTD_CYC - 1) begin
            delay_cnt <= 32'h0;
            state     <= ST_SST;
          end else begin
            delay_cnt <= delay_cnt + 32'h1;
          end
        end
        ST_SST: begin
          if (hard_req) begin
            state      <= ST_RESET;
            core_reset <= 1'b1;
          end else if (delay_cnt >= {24'h0, sst_len} - 32'h1) begin
            state      <= ST_RUN;
            core_reset <= 1'b0;
            core_hold  <= 1'b0;
          end else begin
            delay_cnt <= delay_cnt + 32'h1;
          end
        end
        default: begin
          state      <= ST_RESET;
          core_reset <= 1'b1;
          core_hold  <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM registers: one wait state on every access
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
      timeout_select  <= `WDRC_TSEL_RST;
      dog_enable_key  <= `WDRC_KEY_RST;
    end else begin
      avs_waitrequest <= 1'b1;
      // Write lands only at the edge where the master sees waitrequest low
      if (avs_write && !avs_read && !avs_waitrequest) begin
        case (avs_address)
          `WDRC_ADDR_TSEL: timeout_select <= avs_writedata[2:0];
          `WDRC_ADDR_CTRL: dog_enable_key <= avs_writedata[3:0];
          default: ;
        endcase
      end
      if ((avs_read || avs_write) && avs_waitrequest && !(avs_read && avs_write)) begin
        avs_waitrequest <= 1'b0;
        if (avs_read) begin
          case (avs_address)
            `WDRC_ADDR_TSEL:   avs_readdata <= {29'h0, timeout_select};
            `WDRC_ADDR_CTRL:   avs_readdata <= {28'h0, dog_enable_key};
            `WDRC_ADDR_STATUS: avs_readdata <= {28'h0, sleeping, core_hold,
                                                powerdown_flag, dog_expired_flag};
            `WDRC_ADDR_CAUSE:  avs_readdata <= {30'h0, last_cause};
            default:           avs_readdata <= 32'h0;
          endcase
        end
      end
      if (state != ST_RUN && core_reset) begin
        timeout_select <= `WDRC_TSEL_RST;
      end
    end
  end
endmodule // wdrc_top

/* wdrc_assertions.sv */
// Port-level checker for the watchdog and reset control block
`timescale 1ns/1ps
module wdrc_checker #(
  parameter RSTD_CYC = 20
) (
  input wire       sys_clk,
  input wire       arst_n,
  input wire       external_clear_pin_n,
  input wire       sleep_instruction,
  input wire       avs_read,
  input wire       avs_write,
  input wire       avs_waitrequest,
  input wire       core_reset,
  input wire       pc_sp_clear,
  input wire       core_hold,
  input wire       dog_expired_flag,
  input wire       powerdown_flag,
  input wire [7:0] port_init_value
);
  // Counts from our own view of the pin, so it leads the synchronised copy
  logic [31:0] since_pin;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) since_pin <= 32'h0;
    else if (!external_clear_pin_n) since_pin <= 32'h0;
    else if (since_pin < 32'hffff) since_pin <= since_pin + 32'h1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_port_ones: assert property (port_init_value == 8'hff)
    else $error("port init value not all ones");
  a_pin_resets: assert property (!external_clear_pin_n |-> ##[1:4] core_reset)
    else $error("pin low without core reset");
  a_reset_inhibits: assert property (core_reset |-> core_hold)
    else $error("core reset without hold");
  a_hold_delay: assert property ($fell(core_hold) |-> since_pin >= RSTD_CYC)
    else $error("hold released before reset delay");
  a_sleep_flags: assert property (sleep_instruction && !core_hold
    |-> ##[1:3] (powerdown_flag && !dog_expired_flag))
    else $error("sleep did not update flags");
  a_wake_flags: assert property ($rose(pc_sp_clear)
    |-> ##[0:2] (dog_expired_flag && powerdown_flag))
    else $error("sleep wake flags wrong");
  a_wake_no_reset: assert property (pc_sp_clear |-> !core_reset)
    else $error("sleep wake caused full reset");
  a_wake_pulse: assert property (pc_sp_clear |=> !pc_sp_clear)
    else $error("wake pulse longer than one cycle");
  a_pin_keeps: assert property (!external_clear_pin_n && $past(!external_clear_pin_n)
    |-> $stable(powerdown_flag) && $stable(dog_expired_flag))
    else $error("pin reset changed flags");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest)
    else $error("bus answer late");
endmodule // wdrc_checker
bind wdrc_top wdrc_checker #(.RSTD_CYC(RSTD_CYC)) u_chk (
  .sys_clk(sys_clk), .arst_n(arst_n), .external_clear_pin_n(external_clear_pin_n),
  .sleep_instruction(sleep_instruction), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .core_reset(core_reset), .pc_sp_clear(pc_sp_clear),
  .core_hold(core_hold), .dog_expired_flag(dog_expired_flag),
  .powerdown_flag(powerdown_flag), .port_init_value(port_init_value));

/* wdrc_core_model.sv */
// Core model issuing watchdog clear and sleep strobes
`timescale 1ns/1ps
module wdrc_core_model (
  input  wire       sys_clk,
  input  wire       issue,
  input  wire [1:0] op,
  input  wire       core_hold,
  output reg        clear_watchdog_single,
  output reg        clear_watchdog_first,
  output reg        clear_watchdog_second,
  output reg        sleep_instruction
);
  initial {clear_watchdog_single, clear_watchdog_first} = 2'h0;
  initial {clear_watchdog_second, sleep_instruction} = 2'h0;
  // One-cycle strobes; a held core executes nothing
  always @(posedge sys_clk) begin
    clear_watchdog_single <= issue && !core_hold && op == 2'h0;
    clear_watchdog_first  <= issue && !core_hold && op == 2'h1;
    clear_watchdog_second <= issue && !core_hold && op == 2'h2;
    sleep_instruction     <= issue && !core_hold && op == 2'h3;
  end
endmodule // wdrc_core_model

/* test_watchdog_reset_control.sv */
// Self-checking testbench for the watchdog and reset control block
`timescale 1ns/1ps
module test_watchdog_reset_control;
  logic sys_clk = 0, arst_n = 0, paired = 0, pin_n = 1, bod = 0, issue = 0, dog_en = 1;
  logic [1:0] op = 2'h0, src = 2'h2;
  logic [3:0] div = 4'h0, avs_address = 4'h0;
  logic avs_read = 0, avs_write = 0, seen;
  logic [31:0] avs_writedata = 32'h0, q;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, core_reset, pc_sp_clear, core_hold, sleeping, dog_expired_flag;
  wire powerdown_flag, c_single, c_first, c_second, c_sleep;
  wire [7:0] port_init_value;
  int n_fail = 0, cmp_count = 0, i;
  initial forever #12.5 sys_clk = !sys_clk;
  // Slow watchdog clocks at a quarter of the system rate
  always @(posedge sys_clk) div <= div + 4'h1;
  wdrc_top #(.RSTD_CYC(20)) DUT (.sys_clk(sys_clk), .arst_n(arst_n),
    .cfg_dog_enable(dog_en), .cfg_paired_clear(paired), .cfg_dog_source(src),
    .cfg_osc_type(2'h0), .cfg_short_startup(1'b1), .cfg_lvr_enable(1'b1),
    .external_clear_pin_n(pin_n), .brownout_low(bod), .low_crystal_osc(div[1]),
    .low_internal_rc_osc(div[1]), .clear_watchdog_single(c_single),
    .clear_watchdog_first(c_first), .clear_watchdog_second(c_second),
    .sleep_instruction(c_sleep), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .core_reset(core_reset), .pc_sp_clear(pc_sp_clear),
    .core_hold(core_hold), .sleeping(sleeping), .dog_expired_flag(dog_expired_flag),
    .powerdown_flag(powerdown_flag), .port_init_value(port_init_value));
  wdrc_core_model u_core (.sys_clk(sys_clk), .issue(issue), .op(op), .core_hold(core_hold),
    .clear_watchdog_single(c_single), .clear_watchdog_first(c_first),
    .clear_watchdog_second(c_second), .sleep_instruction(c_sleep));
  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task bus(input logic we, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= we;
    avs_read <= !we;
    // No cycle limit here: the watchdog process ends a hung wait
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(q, e);
  endtask
  task instr(input logic [1:0] o);
    issue <= 1'b1;
    op <= o;
    @(posedge sys_clk);
    issue <= 1'b0;
    @(posedge sys_clk);
  endtask
  task wait_reset(input int n);
    seen = 0;
    repeat (n) begin @(posedge sys_clk); if (core_reset === 1'b1) seen = 1; end
  endtask
  task wait_run;
    for (i = 0; i < 3000 && (core_hold !== 1'b0 || core_reset !== 1'b0); i++)
      @(posedge sys_clk);
    check(i < 3000, 1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin repeat (40000) @(posedge sys_clk); n_fail++; print_verdict; end
  initial begin
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    wait_run;
    check(port_init_value, 8'hff);
    rd(4'h0, 32'h7);
    rd(4'h8, 32'h0);
    rd(4'h2, 32'h0);
    rd(4'h4, 32'ha);
    bus(1'b1, 4'h0, 32'hff);
    rd(4'h0, 32'h7);
    bus(1'b1, 4'h0, 32'h0);
    repeat (4) begin wait_reset(500); check(seen, 0); instr(2'h0); end
    wait_reset(1500);
    check(seen, 1);
    check({dog_expired_flag, powerdown_flag}, 2'b10);
    wait_run;
    rd(4'h0, 32'h7);
    rd(4'hc, 32'h3);
    pin_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    check({core_reset, dog_expired_flag}, 2'b11);
    pin_n <= 1'b1;
    wait_run;
    rd(4'hc, 32'h1);
    bus(1'b1, 4'h0, 32'h0);
    instr(2'h3);
    repeat (4) @(posedge sys_clk);
    check({dog_expired_flag, powerdown_flag}, 2'b01);
    rd(4'h8, 32'ha);
    seen = 0;
    repeat (1500) begin @(posedge sys_clk); if (pc_sp_clear === 1'b1) seen = 1; end
    check({seen, core_reset, dog_expired_flag, powerdown_flag}, 4'b1011);
    bod <= 1'b1;
    repeat (5) @(posedge sys_clk);
    bod <= 1'b0;
    wait_reset(30);
    check(seen, 0);
    bod <= 1'b1;
    wait_reset(20);
    bod <= 1'b0;
    check(seen, 1);
    wait_run;
    rd(4'hc, 32'h2);
    check({dog_expired_flag, powerdown_flag}, 2'b11);
    paired <= 1'b1;
    bus(1'b1, 4'h0, 32'h0);
    for (int j = 0; j < 4; j++) begin instr(j[0] ? 2'h1 : 2'h2); wait_reset(500); check(seen, 0); end
    instr(2'h1);
    wait_reset(700);
    check(seen, 1);
    wait_run;
    dog_en <= 1'b0;
    bus(1'b1, 4'h0, 32'h0);
    wait_reset(1500);
    check(seen, 0);
    bus(1'b1, 4'h4, 32'h5);
    wait_reset(1500);
    check(seen, 1);
    wait_run;
    src <= 2'h1;
    bus(1'b1, 4'h0, 32'h0);
    wait_reset(1500);
    check(seen, 1);
    wait_run;
    bus(1'b1, 4'h0, 32'h0);
    instr(2'h3);
    seen = 0;
    repeat (1500) begin @(posedge sys_clk); if (pc_sp_clear === 1'b1) seen = 1; end
    check({seen, sleeping}, 2'b01);
    pin_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    pin_n <= 1'b1;
    wait_run;
    check(sleeping, 0);
    print_verdict;
  end
endmodule // test_watchdog_reset_control
